// *** inc/quad_pot_pkg.sv ***
package quad_pot_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned NV_WRITE_MS = 10;
  localparam int unsigned NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_MS;

  // ****************************************************************
  // Frame layout, in serial bit counts
  // ****************************************************************
  localparam logic [4:0] ID_LAST_BIT = 5'h07;
  localparam logic [4:0] INSTR_LAST_BIT = 5'h0f;
  localparam logic [4:0] DATA_LAST_BIT = 5'h17;
  localparam int unsigned WIPER_W = 6;
  localparam int unsigned POTS = 4;
  localparam int unsigned REGS_PER_POT = 4;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3f;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;
  localparam logic [WIPER_W-1:0] STORED_RESET = 6'h00;
  localparam logic [3:0] STATUS_LOW_NIBBLE = 4'h1;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_GLOBAL_STORED_TO_WIPER = 4'h1,
    OP_STEP = 4'h2,
    OP_STATUS = 4'h5,
    OP_GLOBAL_WIPER_TO_STORED = 4'h8,
    OP_READ_WIPER = 4'h9,
    OP_WRITE_WIPER = 4'ha,
    OP_READ_STORED = 4'hb,
    OP_WRITE_STORED = 4'hc,
    OP_STORED_TO_WIPER = 4'hd,
    OP_WIPER_TO_STORED = 4'he
  } opcode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ID = 3'h1,
    ST_INSTR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_STEP = 3'h5,
    ST_DONE = 3'h6,
    ST_IGNORE = 3'h7
  } frame_state_e;

endpackage

// *** rtl/nv_write_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// ******************************************************************
// Nonvolatile write cycle timer
// ******************************************************************
module nv_write_timer #(
  parameter int unsigned CYCLES = quad_pot_pkg::NV_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
  } timer_s;

  timer_s q_ff;
  timer_s nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (start) begin
      nxt_q.busy = 1'b1;
      nxt_q.cnt = CW'(CYCLES - 1);
    end else if (q_ff.busy) begin
      if (q_ff.cnt == '0) begin
        nxt_q.busy = 1'b0;
      end else begin
        nxt_q.cnt = q_ff.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign busy = q_ff.busy;

endmodule
`default_nettype wire

// *** rtl/quad_pot_serial_command_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

module quad_pot_serial_command_decoder #(
  // Arbitrary device type code; set to the code the system expects.
  parameter logic [3:0] DEVICE_TYPE = 4'ha,
  parameter int unsigned NV_WRITE_CYCLES = quad_pot_pkg::NV_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic sck,
  input wire logic si,
  input wire logic cs_n,
  output logic so,
  output logic so_oe,
  // Static pins
  input wire logic wp_n,
  input wire logic [1:0] address_select_pins,
  // Wiper positions and status
  output logic [3:0][5:0] wiper_position_register,
  output logic write_in_progress_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic sck_q;
    logic cs_n_q;
    quad_pot_pkg::frame_state_e state;
    logic [4:0] cnt;
    logic [7:0] rx;
    logic [3:0] op;
    logic [1:0] register_selector;
    logic [1:0] pot_selector;
    logic [7:0] tx;
    logic so;
    logic so_oe;
    logic [3:0][5:0] wiper;
    logic [15:0][5:0] stored;
    logic recall;
    logic nv_start;
  } dec_s;

  dec_s q_ff;
  dec_s nxt_q;
  logic nv_busy;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] stored_index(input logic [1:0] pot, input logic [1:0] reg_sel);
    stored_index = {pot, reg_sel};
  endfunction

  function automatic logic [5:0] step_wiper(input logic [5:0] cur, input logic up);
    if (up) begin
      step_wiper = (cur == quad_pot_pkg::WIPER_MAX) ? cur : cur + 6'h01;
    end else begin
      step_wiper = (cur == quad_pot_pkg::WIPER_MIN) ? cur : cur - 6'h01;
    end
  endfunction

  // Synchronised pin views; sync1 is read only by sync2.
  logic s_sck;
  logic s_si;
  logic s_cs_n;
  logic s_wp_n;
  logic [1:0] s_addr;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] rx_byte;
  logic nv_allowed;

  assign s_sck = q_ff.sync2[5];
  assign s_si = q_ff.sync2[4];
  assign s_cs_n = q_ff.sync2[3];
  assign s_wp_n = q_ff.sync2[2];
  assign s_addr = q_ff.sync2[1:0];
  assign sck_rise = s_sck & ~q_ff.sck_q;
  assign sck_fall = ~s_sck & q_ff.sck_q;
  assign cs_fall = ~s_cs_n & q_ff.cs_n_q;
  assign cs_rise = s_cs_n & ~q_ff.cs_n_q;
  assign rx_byte = {q_ff.rx[6:0], s_si};
  // protect gate
  // A store started while the previous one still runs would restart its cycle timer.
  assign nv_allowed = s_wp_n & ~nv_busy;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.sync1 = {sck, si, cs_n, wp_n, address_select_pins};
    nxt_q.sync2 = q_ff.sync1;
    nxt_q.sck_q = s_sck;
    nxt_q.cs_n_q = s_cs_n;
    nxt_q.nv_start = 1'b0;

    if (q_ff.recall) begin
      nxt_q.recall = 1'b0;
      for (int p = 0; p < 4; p++) begin
        nxt_q.wiper[p] = q_ff.stored[stored_index(2'(p), 2'h0)];
      end
    end

    if (cs_rise) begin
      if (q_ff.state == quad_pot_pkg::ST_DONE) begin
        case (q_ff.op)
          quad_pot_pkg::OP_WRITE_WIPER: begin
            nxt_q.wiper[q_ff.pot_selector] = q_ff.rx[5:0];
          end
          quad_pot_pkg::OP_WRITE_STORED: begin
            if (nv_allowed) begin
              nxt_q.stored[stored_index(q_ff.pot_selector, q_ff.register_selector)] =
                q_ff.rx[5:0];
              nxt_q.nv_start = 1'b1;
            end
          end
          quad_pot_pkg::OP_STORED_TO_WIPER: begin
            nxt_q.wiper[q_ff.pot_selector] =
              q_ff.stored[stored_index(q_ff.pot_selector, q_ff.register_selector)];
          end
          quad_pot_pkg::OP_WIPER_TO_STORED: begin
            if (nv_allowed) begin
              nxt_q.stored[stored_index(q_ff.pot_selector, q_ff.register_selector)] =
                q_ff.wiper[q_ff.pot_selector];
              nxt_q.nv_start = 1'b1;
            end
          end
          quad_pot_pkg::OP_GLOBAL_STORED_TO_WIPER: begin
            for (int p = 0; p < 4; p++) begin
              nxt_q.wiper[p] = q_ff.stored[stored_index(2'(p), q_ff.register_selector)];
            end
          end
          quad_pot_pkg::OP_GLOBAL_WIPER_TO_STORED: begin
            if (nv_allowed) begin
              for (int p = 0; p < 4; p++) begin
                nxt_q.stored[stored_index(2'(p), q_ff.register_selector)] = q_ff.wiper[p];
              end
              nxt_q.nv_start = 1'b1;
            end
          end
          default: begin
            nxt_q.op = q_ff.op;
          end
        endcase
      end
      nxt_q.state = quad_pot_pkg::ST_IDLE;
      nxt_q.so_oe = 1'b0;
    end else if (cs_fall) begin
      nxt_q.state = quad_pot_pkg::ST_ID;
      nxt_q.cnt = 5'h00;
      nxt_q.so_oe = 1'b0;
      nxt_q.so = 1'b0;
    end else if (!s_cs_n && sck_rise) begin
      nxt_q.rx = rx_byte;
      nxt_q.cnt = q_ff.cnt + 5'h01;
      case (q_ff.state)
        quad_pot_pkg::ST_ID: begin
          if (q_ff.cnt == quad_pot_pkg::ID_LAST_BIT) begin
            if (rx_byte[7:4] == DEVICE_TYPE && rx_byte[1:0] == s_addr) begin
              nxt_q.state = quad_pot_pkg::ST_INSTR;
            end else begin
              nxt_q.state = quad_pot_pkg::ST_IGNORE;
            end
          end
        end
        quad_pot_pkg::ST_INSTR: begin
          if (q_ff.cnt == quad_pot_pkg::INSTR_LAST_BIT) begin
            nxt_q.op = rx_byte[7:4];
            nxt_q.register_selector = rx_byte[3:2];
            nxt_q.pot_selector = rx_byte[1:0];
            case (rx_byte[7:4])
              quad_pot_pkg::OP_READ_WIPER: begin
                nxt_q.state = quad_pot_pkg::ST_RDATA;
                nxt_q.tx = {2'h0, q_ff.wiper[rx_byte[1:0]]};
              end
              quad_pot_pkg::OP_READ_STORED: begin
                nxt_q.state = quad_pot_pkg::ST_RDATA;
                nxt_q.tx = {2'h0, q_ff.stored[stored_index(rx_byte[1:0], rx_byte[3:2])]};
              end
              quad_pot_pkg::OP_STATUS: begin
                if (rx_byte[3:0] == quad_pot_pkg::STATUS_LOW_NIBBLE) begin
                  nxt_q.state = quad_pot_pkg::ST_RDATA;
                  nxt_q.tx = {7'h00, nv_busy};
                end else begin
                  nxt_q.state = quad_pot_pkg::ST_IGNORE;
                end
              end
              quad_pot_pkg::OP_WRITE_WIPER,
              quad_pot_pkg::OP_WRITE_STORED: begin
                nxt_q.state = quad_pot_pkg::ST_WDATA;
              end
              quad_pot_pkg::OP_STORED_TO_WIPER,
              quad_pot_pkg::OP_WIPER_TO_STORED: begin
                nxt_q.state = quad_pot_pkg::ST_DONE;
              end
              quad_pot_pkg::OP_GLOBAL_STORED_TO_WIPER,
              quad_pot_pkg::OP_GLOBAL_WIPER_TO_STORED: begin
                // The pot field plays no part, since every pot takes part in a global transfer.
                nxt_q.state = quad_pot_pkg::ST_DONE;
              end
              quad_pot_pkg::OP_STEP: begin
                nxt_q.state = quad_pot_pkg::ST_STEP;
              end
              default: begin
                nxt_q.state = quad_pot_pkg::ST_IGNORE;
              end
            endcase
          end
        end
        quad_pot_pkg::ST_WDATA: begin
          if (q_ff.cnt == quad_pot_pkg::DATA_LAST_BIT) begin
            nxt_q.state = quad_pot_pkg::ST_DONE;
          end
        end
        quad_pot_pkg::ST_STEP: begin
          nxt_q.wiper[q_ff.pot_selector] = step_wiper(q_ff.wiper[q_ff.pot_selector], s_si);
        end
        quad_pot_pkg::ST_DONE: begin
          // Extra clocks make the sequence incomplete, so nothing is committed.
          nxt_q.state = quad_pot_pkg::ST_IGNORE;
        end
        quad_pot_pkg::ST_RDATA: begin
          nxt_q.rx = rx_byte;
        end
        default: begin
          nxt_q.rx = q_ff.rx;
          nxt_q.cnt = q_ff.cnt;
        end
      endcase
    end else if (!s_cs_n && sck_fall && q_ff.state == quad_pot_pkg::ST_RDATA) begin
      nxt_q.so = q_ff.tx[7];
      nxt_q.tx = {q_ff.tx[6:0], 1'b0};
      nxt_q.so_oe = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
      // The serial clock idles low, so its flops start low and no false edge follows reset.
      q_ff.sync1 <= 6'h1f;
      q_ff.sync2 <= 6'h1f;
      q_ff.cs_n_q <= 1'b1;
      q_ff.stored <= {16{quad_pot_pkg::STORED_RESET}};
      q_ff.recall <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************************************
  // Nonvolatile write cycle
  // ****************************************************************
  nv_write_timer #(
    .CYCLES(NV_WRITE_CYCLES)
  ) nv_write_timer_i (
    .clk(clk),
    .rst(rst),
    .start(q_ff.nv_start),
    .busy(nv_busy)
  );

  assign so = q_ff.so;
  assign so_oe = q_ff.so_oe;
  assign wiper_position_register = q_ff.wiper;
  assign write_in_progress_flag = nv_busy;

endmodule
`default_nettype wire

// *** dv/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Serial host model
// ****************************************************************
module spi_host_model (
  // System clock, used only to pace the link
  input wire logic clk,
  // Serial link
  output logic sck,
  output logic si,
  output logic cs_n,
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    sck = 1'b0;
    si = 1'b0;
    cs_n = 1'b1;
  end
  task automatic xfer(input int n, input logic [23:0] tx, output logic [7:0] rx,
                      output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = tx[23-i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      rx = {rx[6:0], so};
      oe = oe | so_oe;
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    // A released data line must not keep its last level.
    si = ~si;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** dv/quad_pot_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module quad_pot_chk #(
  parameter int unsigned NV_WRITE_CYCLES = quad_pot_pkg::NV_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic sck,
  input wire logic si,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  // Static pins
  input wire logic wp_n,
  input wire logic [1:0] address_select_pins,
  // Wipers and status
  input wire logic [3:0][5:0] wiper_position_register,
  input wire logic write_in_progress_flag
);
  int unsigned wip_len_ff;
  logic [3:0][5:0] prev_wiper_ff;
  logic step_ok;
  int d;
  always_ff @(posedge clk) begin
    prev_wiper_ff <= wiper_position_register;
    wip_len_ff <= (rst || !write_in_progress_flag) ? '0 : wip_len_ff + 1;
  end
  // A jump of 63 would also catch a wrap at either end of the range.
  always_comb begin
    step_ok = 1'b1;
    for (int p = 0; p < 4; p++) begin
      d = int'(wiper_position_register[p]) - int'(prev_wiper_ff[p]);
      if (d > 1 || d < -1) begin
        step_ok = 1'b0;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    cs_n [*8];
  endsequence
  sequence s_selected;
    !cs_n [*4];
  endsequence
  sequence s_so_shift;
    so_oe && $past(so_oe) && $changed(so);
  endsequence
  a_so_idle_off: assert property (s_quiet |-> !so_oe)
    else $error("so_oe high while deselected");
  a_save_at_rise: assert property ($rose(write_in_progress_flag) |-> cs_n && $past(cs_n, 3))
    else $error("save started inside a frame");
  a_wp_blocks: assert property ($rose(write_in_progress_flag) |-> wp_n && $past(wp_n, 6))
    else $error("save started while protected");
  a_wip_span: assert property ($fell(write_in_progress_flag) |-> wip_len_ff == NV_WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_wip_bound: assert property (write_in_progress_flag |-> wip_len_ff < NV_WRITE_CYCLES)
    else $error("write cycle overran");
  a_wiper_idle: assert property (s_quiet |-> $stable(wiper_position_register))
    else $error("wiper moved while deselected");
  a_step_single: assert property (s_selected |-> step_ok)
    else $error("wiper moved more than one tap");
  a_so_oe_frame: assert property ($rose(so_oe) |-> !cs_n && !$past(cs_n, 8))
    else $error("so_oe rose outside a frame");
  a_so_on_fall: assert property (s_so_shift |-> !$past(sck, 1) && !$past(sck, 3))
    else $error("so changed off a falling clock");
endmodule
bind quad_pot_serial_command_decoder quad_pot_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_i (
  .clk, .rst, .sck, .si, .cs_n, .so, .so_oe, .wp_n, .address_select_pins,
  .wiper_position_register, .write_in_progress_flag);
`default_nettype wire

// *** dv/quad_pot_serial_command_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench top
// ****************************************************************
module quad_pot_serial_command_decoder_tb_top;
  localparam int unsigned NV = 400;
  // Arbitrary device type code for this bench.
  localparam logic [3:0] DTYPE = 4'h6;
  localparam logic [7:0] GOOD = {DTYPE, 4'h2};
  logic clk, rst, wp_n, sck, si, cs_n, so, so_oe, nv_busy, oe;
  logic [1:0] addr;
  logic [3:0][5:0] wiper;
  logic [7:0] rx;
  int failures, n_compared;
  quad_pot_serial_command_decoder #(.DEVICE_TYPE(DTYPE), .NV_WRITE_CYCLES(NV))
    quad_pot_serial_command_decoder_i (.clk(clk), .rst(rst), .sck(sck), .si(si),
    .cs_n(cs_n), .so(so), .so_oe(so_oe), .wp_n(wp_n), .address_select_pins(addr),
    .wiper_position_register(wiper), .write_in_progress_flag(nv_busy));
  spi_host_model spi_host_model_i (.clk(clk), .sck(sck), .si(si), .cs_n(cs_n),
    .so(so), .so_oe(so_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic run(input int n, input logic [7:0] ident, input logic [3:0] op,
                     input logic [1:0] r, input logic [1:0] p, input logic [7:0] dat);
    spi_host_model_i.xfer(n, {ident, op, r, p, dat}, rx, oe);
  endtask
  task automatic wait_nv;
    for (int i = 0; i < 600 && nv_busy !== 1'b0; i++) @(negedge clk);
    chk("flag idle", 8'h00, {7'h00, nv_busy});
  endtask
  task automatic t_reset;
    for (int p = 0; p < 4; p++) chk("reset wiper", 8'h00, {2'h0, wiper[p]});
    chk("reset flag", 8'h00, {7'h00, nv_busy});
  endtask
  task automatic t_wiper;
    run(24, GOOD, quad_pot_pkg::OP_WRITE_WIPER, 2'h0, 2'h1, 8'h2a);
    chk("wiper1", 8'h2a, {2'h0, wiper[1]});
    run(24, GOOD, quad_pot_pkg::OP_READ_WIPER, 2'h0, 2'h1, 8'h00);
    chk("read wiper", 8'h2a, rx);
    chk("read drive", 8'h01, {7'h00, oe});
  endtask
  // The second store lands while the first still runs, so it must be dropped.
  task automatic t_stored;
    run(24, GOOD, quad_pot_pkg::OP_WRITE_STORED, 2'h3, 2'h2, 8'h15);
    chk("flag set", 8'h01, {7'h00, nv_busy});
    run(24, GOOD, quad_pot_pkg::OP_WRITE_STORED, 2'h0, 2'h3, 8'h07);
    run(24, GOOD, quad_pot_pkg::OP_STATUS, 2'h0, 2'h1, 8'h00);
    chk("status busy", 8'h01, rx);
    wait_nv;
    run(24, GOOD, quad_pot_pkg::OP_STATUS, 2'h0, 2'h1, 8'h00);
    chk("status idle", 8'h00, rx);
    run(24, GOOD, quad_pot_pkg::OP_READ_STORED, 2'h3, 2'h2, 8'h00);
    chk("read stored", 8'h15, rx);
    run(24, GOOD, quad_pot_pkg::OP_READ_STORED, 2'h0, 2'h3, 8'h00);
    chk("busy refused", 8'h00, rx);
    run(16, GOOD, quad_pot_pkg::OP_STORED_TO_WIPER, 2'h3, 2'h2, 8'h00);
    chk("load wiper2", 8'h15, {2'h0, wiper[2]});
  endtask
  task automatic t_transfer;
    run(16, GOOD, quad_pot_pkg::OP_WIPER_TO_STORED, 2'h2, 2'h1, 8'h00);
    chk("save flag", 8'h01, {7'h00, nv_busy});
    wait_nv;
    run(24, GOOD, quad_pot_pkg::OP_READ_STORED, 2'h2, 2'h1, 8'h00);
    chk("saved wiper1", 8'h2a, rx);
    run(24, GOOD, quad_pot_pkg::OP_WRITE_WIPER, 2'h0, 2'h3, 8'h3f);
    run(16, GOOD, quad_pot_pkg::OP_GLOBAL_WIPER_TO_STORED, 2'h1, 2'h0, 8'h00);
    wait_nv;
  endtask
  task automatic t_step;
    run(18, GOOD, quad_pot_pkg::OP_STEP, 2'h0, 2'h3, 8'hff);
    chk("step top", 8'h3f, {2'h0, wiper[3]});
    run(18, GOOD, quad_pot_pkg::OP_STEP, 2'h0, 2'h0, 8'h00);
    chk("step bottom", 8'h00, {2'h0, wiper[0]});
    run(19, GOOD, quad_pot_pkg::OP_STEP, 2'h0, 2'h1, 8'h00);
    chk("step down", 8'h27, {2'h0, wiper[1]});
    run(19, GOOD, quad_pot_pkg::OP_STEP, 2'h0, 2'h2, 8'ha0);
    chk("step mixed", 8'h16, {2'h0, wiper[2]});
    run(16, GOOD, quad_pot_pkg::OP_GLOBAL_STORED_TO_WIPER, 2'h2, 2'h1, 8'h00);
    chk("global any pot", 8'h00, {2'h0, wiper[2]});
    chk("global pot field", 8'h2a, {2'h0, wiper[1]});
    run(16, GOOD, quad_pot_pkg::OP_GLOBAL_STORED_TO_WIPER, 2'h1, 2'h0, 8'h00);
    chk("global w1", 8'h2a, {2'h0, wiper[1]});
    chk("global w2", 8'h15, {2'h0, wiper[2]});
    chk("global w3", 8'h3f, {2'h0, wiper[3]});
  endtask
  task automatic t_refuse;
    wp_n = 1'b0;
    run(24, GOOD, quad_pot_pkg::OP_WRITE_STORED, 2'h0, 2'h0, 8'h11);
    chk("protected", 8'h00, {7'h00, nv_busy});
    wp_n = 1'b1;
    run(23, GOOD, quad_pot_pkg::OP_WRITE_STORED, 2'h0, 2'h0, 8'h11);
    chk("short frame", 8'h00, {7'h00, nv_busy});
    run(17, GOOD, quad_pot_pkg::OP_STORED_TO_WIPER, 2'h0, 2'h1, 8'h00);
    chk("extra clock", 8'h2a, {2'h0, wiper[1]});
    run(24, {DTYPE, 4'h1}, quad_pot_pkg::OP_WRITE_WIPER, 2'h0, 2'h0, 8'h11);
    chk("bad address", 8'h00, {2'h0, wiper[0]});
    run(24, {4'h3, 4'h2}, quad_pot_pkg::OP_WRITE_WIPER, 2'h0, 2'h0, 8'h11);
    chk("bad type", 8'h00, {2'h0, wiper[0]});
    run(24, {DTYPE, 4'h1}, quad_pot_pkg::OP_READ_STORED, 2'h0, 2'h0, 8'h00);
    chk("silent read", 8'h00, {7'h00, oe});
    run(24, GOOD, quad_pot_pkg::OP_STATUS, 2'h0, 2'h0, 8'h00);
    chk("bad status", 8'h00, {7'h00, oe});
    run(24, GOOD, quad_pot_pkg::OP_READ_STORED, 2'h0, 2'h0, 8'h00);
    chk("unsaved", 8'h00, rx);
  endtask
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    addr = 2'h2;
    failures = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_wiper;
    t_stored;
    t_transfer;
    t_step;
    t_refuse;
    finish_test;
  end
  // The sequence needs about 5700 clocks; this allows about seven times that.
  initial begin
    #1000000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
